//--- logic/zbs_sram_ctrl.sv
// Behaviour
// - adv low, any select off: deselect, Hi-Z
// - adv high after deselect stays deselected
// - read or write fixed at begin burst
// - selected read with output enable off: dummy
// - dummy read, write abort: no access, no drive
// - all write masks high: abort, Hi-Z
// - drivers off during any write cycle
// - qualifier high: edge ignored, state held
// - stall during read keeps lanes driven
// - stall during write keeps lanes Hi-Z
// - no array write on stalled edge
// - any write mask low means write
// - each mask writes exactly its own lane
// - any lane combination writable at once
// - counter advances every continue burst cycle
// - order low: linear modulo four sequence
// - order high: start xor count sequence
// - read/write select decides at address load
// - sleep ignores inputs, holds array, Hi-Z
//
// Added by the designer: the register addresses and the Wishbone interface to the registers.
module zbs_sram_ctrl #(
  parameter int ADDR_W = zbs_pkg::ADDR_W_DEF,
  parameter int LANES = zbs_pkg::LANES_DEF,
  parameter int LANE_W = zbs_pkg::LANE_W_DEF
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire zbs_pkg::zbs_pins_s pins_in,
  input wire logic [ADDR_W-1:0] address_in,
  input wire logic [LANES-1:0] byte_lane_write_n_in,
  input wire logic [LANES*LANE_W-1:0] data_lane_in,
  output logic [LANES*LANE_W-1:0] data_lane_out,
  output logic [LANES-1:0] data_lane_oe_out,
  input wire zbs_pkg::zbs_wb_req_s wb_req_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out
);

  localparam int DATA_W = LANES * LANE_W;
  localparam int PINS_W = $bits(zbs_pkg::zbs_pins_s);
  localparam int SYNC_W = PINS_W + ADDR_W + LANES + DATA_W;
  localparam int DEPTH = 1 << ADDR_W;
  localparam int CW = zbs_pkg::CNT_W;

  if (!(LANES == 2 || LANES == 4) || LANE_W < 1 || ADDR_W < 3 || ADDR_W > 20) begin : g_chk
    $error("zbs_sram_ctrl: unsupported geometry");
  end

  if (zbs_pkg::CNT_W < 1 || zbs_pkg::CNT_W > 32) begin : g_cnt_chk
    $error("zbs_sram_ctrl: event counters must fit a 32-bit register");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    zbs_pkg::zbs_state_e state;
    logic wr_pend;
    logic [ADDR_W-1:0] wr_addr;
    logic [LANES-1:0] wr_mask;
    logic [DATA_W-1:0] rd_data;
    logic ack;
    logic [31:0] wb_rdata;
    logic [1:0] ctrl;
    logic [CW-1:0] wr_cnt;
    logic [CW-1:0] abort_cnt;
    logic [CW-1:0] stall_cnt;
  } zbs_main_s;

  zbs_main_s r_reg;
  zbs_main_s r_next;

  logic [DATA_W-1:0] mem [DEPTH];

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] sync_q;
  zbs_pkg::zbs_pins_s s_pins;
  logic [ADDR_W-1:0] s_addr;
  logic [LANES-1:0] s_bw_n;
  logic [DATA_W-1:0] s_data;

  zbs_sync #(
    .W(SYNC_W)
  ) u_sync (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .d_in({pins_in, address_in, byte_lane_write_n_in, data_lane_in}),
    .q_out(sync_q)
  );

  assign {s_pins, s_addr, s_bw_n, s_data} = sync_q;

  // ----------------------------------------------------------------
  // burst counter
  // ----------------------------------------------------------------
  logic burst_load;
  logic burst_step;
  logic interleave;
  logic [ADDR_W-1:0] burst_cur;
  logic [ADDR_W-1:0] burst_next;

  // software may pin the order; otherwise the order input rules
  assign interleave = r_reg.ctrl[zbs_pkg::ZBS_CTRL_OVR_EN_BIT] ?
                      r_reg.ctrl[zbs_pkg::ZBS_CTRL_OVR_VAL_BIT] : s_pins.burst_order;

  zbs_burst_addr #(
    .ADDR_W(ADDR_W)
  ) u_burst (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .load_in(burst_load),
    .step_in(burst_step),
    .interleave_in(interleave),
    .load_addr_in(s_addr),
    .cur_addr_out(burst_cur),
    .next_addr_out(burst_next)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [DATA_W-1:0] zbs_merge(input logic [DATA_W-1:0] old_w,
                                                  input logic [DATA_W-1:0] new_w,
                                                  input logic [LANES-1:0] mask);
    zbs_merge = old_w;
    for (int i = 0; i < LANES; i++) begin
      if (mask[i]) begin
        zbs_merge[i*LANE_W +: LANE_W] = new_w[i*LANE_W +: LANE_W];
      end
    end
  endfunction

  function automatic logic [CW-1:0] zbs_count(input logic [CW-1:0] cnt, input logic clr,
                                              input logic inc);
    // an event in the clearing cycle still counts
    zbs_count = clr ? CW'(inc) : CW'(cnt + CW'(inc));
  endfunction

  // a register write lands only on the acked edge of a matching request
  function automatic logic zbs_wr_at(input zbs_pkg::zbs_wb_req_s req, input logic acked,
                                     input logic [7:0] off);
    zbs_wr_at = req.cyc && req.stb && req.we && acked && (req.adr == off);
  endfunction

  function automatic logic [31:0] zbs_status(input zbs_pkg::zbs_state_e st,
                                             input logic [1:0] burst_lo,
                                             input logic sleep, input logic drive,
                                             input logic pend);
    zbs_status = '0;
    zbs_status[zbs_pkg::ZBS_STAT_STATE_LSB +: 2] = st;
    zbs_status[zbs_pkg::ZBS_STAT_BURST_LSB +: 2] = burst_lo;
    zbs_status[zbs_pkg::ZBS_STAT_SLEEP_BIT] = sleep;
    zbs_status[zbs_pkg::ZBS_STAT_DRIVE_BIT] = drive;
    zbs_status[zbs_pkg::ZBS_STAT_PEND_BIT] = pend;
  endfunction

  // ----------------------------------------------------------------
  // cycle decode and write stage
  // ----------------------------------------------------------------
  logic cs_ok;
  logic [ADDR_W-1:0] cyc_addr;
  logic [LANES-1:0] mem_lane_we;
  logic [LANES-1:0] fwd_mask;
  logic inc_wr;
  logic inc_abort;
  logic inc_stall;
  logic wb_hit;
  logic wb_wr;
  logic [31:0] status_word;
  logic [31:0] rd_word;

  assign cs_ok = !s_pins.select_primary_n && s_pins.select_secondary &&
                 !s_pins.select_tertiary_n;

  always_comb begin
    r_next = r_reg;
    burst_load = 1'h0;
    burst_step = 1'h0;
    mem_lane_we = '0;
    fwd_mask = '0;
    inc_wr = 1'h0;
    inc_abort = 1'h0;
    inc_stall = 1'h0;
    cyc_addr = s_pins.burst_step_or_load ? burst_next : s_addr;
    if (s_pins.sleep_request) begin
      // pending work is dropped, array untouched
      r_next.state = zbs_pkg::ZBS_ST_DESEL;
      r_next.wr_pend = 1'h0;
    end else if (s_pins.clock_qualify_n) begin
      inc_stall = 1'h1;
    end else begin
      if (r_reg.wr_pend) begin
        mem_lane_we = r_reg.wr_mask;
        fwd_mask = (r_reg.wr_addr == cyc_addr) ? r_reg.wr_mask : '0;
        inc_wr = |r_reg.wr_mask;
      end
      r_next.wr_pend = 1'h0;
      if (!s_pins.burst_step_or_load) begin
        if (!cs_ok) begin
          r_next.state = zbs_pkg::ZBS_ST_DESEL;
        end else begin
          burst_load = 1'h1;
          r_next.state = s_pins.read_write_n ? zbs_pkg::ZBS_ST_READ :
                         zbs_pkg::ZBS_ST_WRITE;
        end
      end else if (r_reg.state == zbs_pkg::ZBS_ST_DESEL) begin
        r_next.state = zbs_pkg::ZBS_ST_DESEL;
      end else begin
        burst_step = 1'h1;
      end
      if (r_next.state == zbs_pkg::ZBS_ST_WRITE) begin
        // data for this write arrives one edge later
        r_next.wr_pend = 1'h1;
        r_next.wr_addr = cyc_addr;
        r_next.wr_mask = ~s_bw_n;
        inc_abort = &s_bw_n;
      end else if (r_next.state == zbs_pkg::ZBS_ST_READ) begin
        // newest data wins, even if still in the write stage
        r_next.rd_data = zbs_merge(mem[cyc_addr], s_data, fwd_mask);
      end
    end

    // ----------------------------------------------------------------
    // register slave
    // ----------------------------------------------------------------
    status_word = zbs_status(r_reg.state, burst_cur[1:0], s_pins.sleep_request,
                             |data_lane_oe_out, r_reg.wr_pend);
    wb_hit = wb_req_in.cyc && wb_req_in.stb;
    wb_wr = wb_hit && wb_req_in.we && r_reg.ack;
    r_next.ack = wb_hit && !r_reg.ack;
    case (wb_req_in.adr)
      zbs_pkg::ZBS_OFF_CTRL: rd_word = {30'h0, r_reg.ctrl};
      zbs_pkg::ZBS_OFF_STATUS: rd_word = status_word;
      zbs_pkg::ZBS_OFF_WR_CNT: rd_word = 32'(r_reg.wr_cnt);
      zbs_pkg::ZBS_OFF_ABORT_CNT: rd_word = 32'(r_reg.abort_cnt);
      zbs_pkg::ZBS_OFF_STALL_CNT: rd_word = 32'(r_reg.stall_cnt);
      default: rd_word = 32'h0;
    endcase
    if (wb_hit && !r_reg.ack) begin
      r_next.wb_rdata = rd_word;
    end
    if (wb_wr && wb_req_in.adr == zbs_pkg::ZBS_OFF_CTRL && wb_req_in.sel[0]) begin
      r_next.ctrl = wb_req_in.dat[1:0];
    end
    r_next.wr_cnt = zbs_count(r_reg.wr_cnt,
                              zbs_wr_at(wb_req_in, r_reg.ack, zbs_pkg::ZBS_OFF_WR_CNT),
                              inc_wr);
    r_next.abort_cnt = zbs_count(r_reg.abort_cnt,
                                 zbs_wr_at(wb_req_in, r_reg.ack, zbs_pkg::ZBS_OFF_ABORT_CNT),
                                 inc_abort);
    r_next.stall_cnt = zbs_count(r_reg.stall_cnt,
                                 zbs_wr_at(wb_req_in, r_reg.ack, zbs_pkg::ZBS_OFF_STALL_CNT),
                                 inc_stall);
  end

  // ----------------------------------------------------------------
  // registers and array
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      r_reg <= '0;
      r_reg.ctrl <= zbs_pkg::ZBS_CTRL_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  // array has no reset; contents survive sleep
  always_ff @(posedge ref_clk_in) begin
    for (int i = 0; i < LANES; i++) begin
      if (mem_lane_we[i]) begin
        mem[r_reg.wr_addr][i*LANE_W +: LANE_W] <= s_data[i*LANE_W +: LANE_W];
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // a stall holds the state, so a read keeps driving and a write stays off
  always_comb begin
    data_lane_oe_out = '0;
    if (r_reg.state == zbs_pkg::ZBS_ST_READ && !s_pins.output_enable_n &&
        !s_pins.sleep_request) begin
      data_lane_oe_out = '1;
    end
  end

  assign data_lane_out = r_reg.rd_data;
  assign wb_dat_out = r_reg.wb_rdata;
  assign wb_ack_out = r_reg.ack;

endmodule

//--- logic/zbs_pkg.sv
package zbs_pkg;

  // ----------------------------------------------------------------
  // geometry defaults
  // ----------------------------------------------------------------
  localparam int ADDR_W_DEF = 17;
  localparam int LANES_DEF = 4;
  localparam int LANE_W_DEF = 9;
  localparam int SYNC_STAGES = 2;
  localparam int CNT_W = 16;

  // ----------------------------------------------------------------
  // cycle state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ZBS_ST_DESEL = 2'h0,
    ZBS_ST_READ  = 2'h1,
    ZBS_ST_WRITE = 2'h3
  } zbs_state_e;

  // ----------------------------------------------------------------
  // register map, byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ZBS_OFF_CTRL = 8'h00;
  localparam logic [7:0] ZBS_OFF_STATUS = 8'h04;
  localparam logic [7:0] ZBS_OFF_WR_CNT = 8'h08;
  localparam logic [7:0] ZBS_OFF_ABORT_CNT = 8'h0C;
  localparam logic [7:0] ZBS_OFF_STALL_CNT = 8'h10;

  localparam int ZBS_CTRL_OVR_EN_BIT = 0;
  localparam int ZBS_CTRL_OVR_VAL_BIT = 1;
  localparam logic [1:0] ZBS_CTRL_RESET = 2'h0;

  localparam int ZBS_STAT_STATE_LSB = 0;
  localparam int ZBS_STAT_BURST_LSB = 2;
  localparam int ZBS_STAT_SLEEP_BIT = 4;
  localparam int ZBS_STAT_DRIVE_BIT = 5;
  localparam int ZBS_STAT_PEND_BIT = 6;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic select_primary_n;
    logic select_secondary;
    logic select_tertiary_n;
    logic burst_step_or_load;
    logic read_write_n;
    logic clock_qualify_n;
    logic output_enable_n;
    logic sleep_request;
    logic burst_order;
  } zbs_pins_s;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } zbs_wb_req_s;

endpackage

//--- logic/zbs_sync.sv
module zbs_sync #(
  parameter int W = 1
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } zbs_sync_s;

  zbs_sync_s r_reg;
  zbs_sync_s r_next;

  if (W < 1) begin : g_chk
    $error("zbs_sync: width must be positive");
  end

  // first stage feeds the second and nothing else
  always_comb begin
    r_next.s1 = d_in;
    r_next.s2 = r_reg.s1;
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign q_out = r_reg.s2;

endmodule

//--- logic/zbs_burst_addr.sv
module zbs_burst_addr #(
  parameter int ADDR_W = zbs_pkg::ADDR_W_DEF
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic load_in,
  input wire logic step_in,
  input wire logic interleave_in,
  input wire logic [ADDR_W-1:0] load_addr_in,
  output logic [ADDR_W-1:0] cur_addr_out,
  output logic [ADDR_W-1:0] next_addr_out
);

  typedef struct packed {
    logic [ADDR_W-3:0] upper;
    logic [1:0] start;
    logic [1:0] count;
  } zbs_burst_s;

  zbs_burst_s r_reg;
  zbs_burst_s r_next;

  if (ADDR_W < 3) begin : g_chk
    $error("zbs_burst_addr: address needs at least three bits");
  end

  function automatic logic [1:0] zbs_lo(input logic [1:0] start, input logic [1:0] count,
                                        input logic il);
    if (il) begin
      zbs_lo = start ^ count;
    end else begin
      zbs_lo = 2'(start + count);
    end
  endfunction

  always_comb begin
    r_next = r_reg;
    if (load_in) begin
      r_next.upper = load_addr_in[ADDR_W-1:2];
      r_next.start = load_addr_in[1:0];
      r_next.count = 2'h0;
    end else if (step_in) begin
      r_next.count = 2'(r_reg.count + 2'h1);
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // wraps inside an aligned group of four
  assign cur_addr_out = {r_reg.upper, zbs_lo(r_reg.start, r_reg.count, interleave_in)};
  assign next_addr_out = {r_reg.upper,
                          zbs_lo(r_reg.start, 2'(r_reg.count + 2'h1), interleave_in)};

endmodule

//--- verification/zbs_sram_ctrl_chk.sv
module zbs_sram_ctrl_chk #(
  parameter int LANES = zbs_pkg::LANES_DEF
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire zbs_pkg::zbs_pins_s pins_in,
  input wire logic [LANES-1:0] data_lane_oe_out,
  input wire zbs_pkg::zbs_wb_req_s wb_req_in,
  input wire logic wb_ack_out
);
  timeunit 1ns;
  timeprecision 1ns;
  zbs_pkg::zbs_pins_s p;
  logic sel;
  logic go;
  logic [LANES-1:0] oe;
  assign p = pins_in;
  assign oe = data_lane_oe_out;
  assign sel = !p.select_primary_n && p.select_secondary && !p.select_tertiary_n;
  assign go = !p.clock_qualify_n && !p.sleep_request;

  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);

  // ------------------------------------------------------------
  // pin cycles, seen two edges before the command edge
  // ------------------------------------------------------------
  sequence s_ds; go && !p.burst_step_or_load && !sel; endsequence
  sequence s_rd; go && !p.burst_step_or_load && sel && p.read_write_n; endsequence
  sequence s_wr; go && !p.burst_step_or_load && sel && !p.read_write_n; endsequence
  sequence s_ct; go && p.burst_step_or_load; endsequence
  sequence s_stl; p.clock_qualify_n && !p.sleep_request; endsequence
  sequence s_on; !p.output_enable_n && !p.sleep_request; endsequence

  a_desel_quiet: assert property (s_ds |-> ##3 oe == '0)
    else $error("deselect drove the lanes");
  a_cont_desel: assert property (s_ds ##1 s_ct |-> ##3 oe == '0)
    else $error("continue after deselect drove the lanes");
  a_type_kept: assert property (s_wr ##1 s_stl ##1 s_ct |-> ##3 oe == '0)
    else $error("write burst turned into a read");
  a_dummy_quiet: assert property (s_rd ##0 p.output_enable_n ##1 p.output_enable_n
    |-> ##2 oe == '0)
    else $error("dummy read drove the lanes");
  a_write_off: assert property (s_wr |-> ##3 oe == '0)
    else $error("write cycle drove the lanes");
  a_read_on: assert property (s_rd ##1 s_on |-> ##2 oe == '1)
    else $error("read did not drive the lanes");
  a_stall_read: assert property (s_stl ##1 s_on ##1 (oe == '1) |-> ##1 oe == '1)
    else $error("stall released a read");
  a_stall_write: assert property (s_wr ##1 s_stl |-> ##3 oe == '0)
    else $error("stall in write drove the lanes");
  a_sleep_off: assert property (p.sleep_request [*2] |-> ##1 oe == '0)
    else $error("sleep left the lanes driven");
  a_ack_pulse: assert property (wb_req_in.cyc && wb_req_in.stb && !wb_ack_out
    |=> wb_ack_out ##1 !wb_ack_out)
    else $error("bus ack not a single pulse");
endmodule

bind zbs_sram_ctrl zbs_sram_ctrl_chk #(.LANES(LANES)) chk_u (
  .ref_clk_in(ref_clk_in),
  .rst_n_in(rst_n_in),
  .pins_in(pins_in),
  .data_lane_oe_out(data_lane_oe_out),
  .wb_req_in(wb_req_in),
  .wb_ack_out(wb_ack_out)
);

//--- verification/zbs_ctl_model.sv
module zbs_ctl_model #(
  parameter int AW = 6,
  parameter int DW = 36
) (
  input wire logic ref_clk_in,
  output zbs_pkg::zbs_pins_s pins_out,
  output logic [AW-1:0] addr_out,
  output logic [3:0] mask_n_out,
  output logic [DW-1:0] wdata_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic order = 1'b0;
  logic wmode = 1'b0;
  logic [DW-1:0] pend = '0;
  int nwr = 0;
  int nab = 0;
  int nst = 0;

  initial begin
    pins_out = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
    addr_out = '0;
    mask_n_out = 4'hF;
    wdata_out = '0;
  end

  // ------------------------------------------------------------
  // one bus cycle; write data trails its command by one cycle
  // ------------------------------------------------------------
  task automatic step(input logic [2:0] sel, input logic adv, rw, cqn, oen, zz,
                      input logic [AW-1:0] a, input logic [3:0] m, input logic [DW-1:0] d);
    @(posedge ref_clk_in);
    pins_out <= '{sel[2], sel[1], sel[0], adv, rw, cqn, oen, zz, order};
    addr_out <= a;
    mask_n_out <= m;
    wdata_out <= pend;
    if (!cqn && !zz) begin
      if (!adv) wmode = (sel == 3'b010) && !rw;
      // released lanes toggle so a stale value never looks valid
      pend = wmode ? d : ~pend;
      if (wmode && m == 4'hF) nab++;
      else if (wmode) nwr++;
    end
    if (cqn && !zz) nst++;
  endtask
endmodule

//--- verification/test_zero_turnaround_burst_sram_control.sv
module test_zero_turnaround_burst_sram_control;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int AW = 6;
  localparam int DW = 36;
  logic ref_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  zbs_pkg::zbs_pins_s pins;
  zbs_pkg::zbs_wb_req_s wb_req = '0;
  logic [AW-1:0] addr;
  logic [3:0] mask_n;
  logic [3:0] oe;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;
  logic [DW-1:0] bus;
  logic [31:0] wb_dat;
  logic [31:0] q;
  logic wb_ack;
  logic [DW-1:0] exp_mem [64];
  logic [2:0] dsv [3] = '{3'b110, 3'b000, 3'b011};
  int bad_count = 0;
  int n_tests = 0;

  always #20 ref_clk_in = ~ref_clk_in;

  for (genvar l = 0; l < 4; l++) begin : g_bus
    assign bus[l*9 +: 9] = oe[l] ? rdata[l*9 +: 9] : wdata[l*9 +: 9];
  end

  zbs_ctl_model #(.AW(AW), .DW(DW)) ctl_u (.ref_clk_in(ref_clk_in), .pins_out(pins),
    .addr_out(addr), .mask_n_out(mask_n), .wdata_out(wdata));

  zbs_sram_ctrl #(.ADDR_W(AW), .LANES(4), .LANE_W(9)) dut_u (.ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in), .pins_in(pins), .address_in(addr), .byte_lane_write_n_in(mask_n),
    .data_lane_in(bus), .data_lane_out(rdata), .data_lane_oe_out(oe), .wb_req_in(wb_req),
    .wb_dat_out(wb_dat), .wb_ack_out(wb_ack));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic wrap_up();
    if (bad_count == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic check(input logic [DW-1:0] got, input logic [DW-1:0] want);
    n_tests++;
    if (got !== want) begin
      bad_count++;
      $display("[FAIL] %0t got %h want %h", $time, got, want);
    end
  endtask

  function automatic logic [DW-1:0] dat(input logic [AW-1:0] a);
    return {4{3'h5, a}};
  endfunction

  task automatic upd(input logic [AW-1:0] a, input logic [3:0] m, input logic [DW-1:0] d);
    for (int l = 0; l < 4; l++)
      if (!m[l]) exp_mem[a][l*9 +: 9] = d[l*9 +: 9];
  endtask

  task automatic wr(input logic [AW-1:0] a, input logic [3:0] m, input logic [DW-1:0] d);
    ctl_u.step(3'b010, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, a, m, d);
    upd(a, m, d);
  endtask

  // continue cycles carry a wrong address on purpose: the device must ignore it
  task automatic cnt(input logic [AW-1:0] a, input logic [3:0] m, input logic [DW-1:0] d);
    ctl_u.step(3'b010, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, ~a, m, d);
    upd(a, m, d);
  endtask

  task automatic stl();
    ctl_u.step(3'b010, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, '0, 4'h0, '1);
  endtask

  task automatic dsl(input logic [2:0] s);
    ctl_u.step(s, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, '0, 4'h0, '0);
  endtask

  task automatic rd_burst(input logic [AW-1:0] s);
    logic [AW-1:0] a;
    int k;
    for (int j = 0; j < 8; j++) begin
      k = (j < 5) ? 0 : j - 4;
      a = {s[AW-1:2], ctl_u.order ? s[1:0] ^ 2'(k) : s[1:0] + 2'(k)};
      if (j == 0) ctl_u.step(3'b010, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, s, 4'h0, '0);
      else if (j == 1) stl();
      else if (j < 5) cnt(a, 4'hF, '0);
      else dsl(3'b110);
      if (j > 2) begin
        @(negedge ref_clk_in);
        check(rdata, exp_mem[a]);
        check(36'(oe), 36'hF);
      end
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    @(posedge ref_clk_in);
    wb_req <= '{1'b1, 1'b1, w, a, 4'hF, d};
    do begin
      @(posedge ref_clk_in);
    end while (wb_ack !== 1'b1);
    r = wb_dat;
    wb_req <= '0;
  endtask

  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    repeat (6) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    wr(6'h13, 4'h0, dat(6'h13));
    wr(6'h10, 4'h0, dat(6'h10));
    wr(6'h11, 4'h0, dat(6'h11));
    stl();
    cnt(6'h12, 4'h0, dat(6'h12));
    cnt(6'h13, 4'hF, '1);
    cnt(6'h10, 4'hB, ~dat(6'h10));
    wr(6'h12, 4'hD, ~dat(6'h12));
    repeat (2) dsl(3'b110);
    repeat (3) ctl_u.step(3'b010, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 6'h11, 4'h0, '0);
    repeat (3) dsl(3'b110);
    rd_burst(6'h11);
    ctl_u.order = 1'b1;
    repeat (2) dsl(3'b000);
    rd_burst(6'h13);
    for (int v = 0; v < 3; v++) begin
      ctl_u.step(3'b010, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 6'h12, 4'h0, '0);
      dsl(dsv[v]);
      ctl_u.step(dsv[v], 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 6'h12, 4'h0, '0);
    end
    ctl_u.step(3'b010, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 6'h10, 4'h0, '0);
    ctl_u.step(3'b010, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 6'h10, 4'h0, '0);
    repeat (4) dsl(3'b110);
    wb(1'b0, zbs_pkg::ZBS_OFF_WR_CNT, '0, q);
    check(36'(q), 36'(ctl_u.nwr));
    wb(1'b0, zbs_pkg::ZBS_OFF_ABORT_CNT, '0, q);
    check(36'(q), 36'(ctl_u.nab));
    wb(1'b0, zbs_pkg::ZBS_OFF_STALL_CNT, '0, q);
    check(36'(q), 36'(ctl_u.nst));
    wb(1'b1, zbs_pkg::ZBS_OFF_STALL_CNT, 32'h0000_00FF, q);
    wb(1'b0, zbs_pkg::ZBS_OFF_STALL_CNT, '0, q);
    check(36'(q), 36'h0);
    wb(1'b1, zbs_pkg::ZBS_OFF_CTRL, 32'h0000_0003, q);
    wb(1'b0, zbs_pkg::ZBS_OFF_CTRL, '0, q);
    check(36'(q), 36'h3);
    wb(1'b1, zbs_pkg::ZBS_OFF_CTRL, 32'h0000_0000, q);
    wb(1'b0, 8'h20, '0, q);
    check(36'(q), 36'h0);
    wrap_up();
  end

  initial begin
    #200000;
    bad_count++;
    wrap_up();
  end
endmodule
